// >>> sgfc_pkg.sv
// Package of constants and types for the global frame control registers
// Summary of operation
// (R01) Huge bit accepts up to 1916 bytes
// (R02) Size check disable accepts up to 1536
// (R03) Default limits 1522 tagged, 1518 untagged
// (R04) Special-tagged CPU frames count as untagged
// (R05) Drop frames longer than selected limit
// (R06) VLAN enable bit turns on VLAN forwarding; here it only blocks the tag mask (R11)
// (R07) IGMP snoop forwards IGMP frames to host
// (R08) Direct mode forwards by host preamble
// (R09) Pre-tag prefixes ingress port in preamble
// (R10) Tag mask uses VID low five bits
// (R11) Tag mask only while VLAN disabled
// (R12) Sniff select set needs both ports match
// (R13) Sniff select clear needs either match
// (R14) Back pressure bit enables host-port backpressure
// (R15) Size check disable resets from strap pin
// (R16) Reserved bits read zero, writes ignored
package sgfc_pkg;
  localparam logic [7:0]  ADDR_FRAME_SIZE = 8'h04;
  localparam logic [7:0]  ADDR_FORWARDING = 8'h05;
  localparam logic [7:0]  ADDR_HOST_PORT  = 8'h06;
  localparam int          BIT_HUGE        = 2;
  localparam int          BIT_LEGAL_DIS   = 1;
  localparam int          BIT_VLAN_EN     = 7;
  localparam int          BIT_IGMP_SNOOP  = 6;
  localparam int          BIT_DIRECT      = 5;
  localparam int          BIT_PRE_TAG     = 4;
  localparam int          BIT_TAG_MASK    = 1;
  localparam int          BIT_SNIFF_AND   = 0;
  localparam int          BIT_BACK_PRESS  = 7;
  localparam logic [7:0]  MASK_FRAME_SIZE = 8'h06;
  localparam logic [7:0]  MASK_FORWARDING = 8'hf3;
  localparam logic [7:0]  MASK_HOST_PORT  = 8'h80;
  localparam logic [7:0]  RST_FRAME_SIZE  = 8'h00;
  localparam logic [7:0]  RST_FORWARDING  = 8'h00;
  localparam logic [7:0]  RST_HOST_PORT   = 8'h00;
  localparam logic [10:0] LEN_HUGE        = 11'h77c;
  localparam logic [10:0] LEN_LEGAL_DIS   = 11'h600;
  localparam logic [10:0] LEN_TAGGED      = 11'h5f2;
  localparam logic [10:0] LEN_UNTAGGED    = 11'h5ee;
  localparam int          PORTS           = 5;

  typedef struct packed {
    logic        huge;
    logic        legal_dis;
    logic        vlan_en;
    logic        igmp_snoop;
    logic        direct;
    logic        pre_tag;
    logic        tag_mask;
    logic        sniff_and;
    logic        back_press;
  } sgfc_ctrl_s;

  typedef struct packed {
    logic        valid;
    logic [10:0] length;
    logic        vlan_tagged;
    logic        special_tag;
    logic        is_igmp;
    logic [4:0]  vid_low;
    logic [4:0]  lookup_ports;
    logic [4:0]  preamble_ports;
    logic        from_host;
    logic [2:0]  src_port;
    logic        sniff_src_hit;
    logic        sniff_dst_hit;
  } sgfc_frame_s;

  typedef struct packed {
    logic        valid;
    logic        drop;
    logic [4:0]  dest_ports;
    logic        mirror;
    logic        pre_tag_en;
    logic [2:0]  pre_tag_port;
  } sgfc_decision_s;
endpackage

// >>> sgfc_sync.sv
// Two-stage synchroniser for the strap pin
`timescale 1ns/1ns
module sgfc_sync (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  always_comb begin
    next_stage1   = clk_en ? async_in : stage1;
    next_sync_out = clk_en ? stage1 : sync_out;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule // sgfc_sync

// >>> sgfc_ctrl.sv
// Global frame control registers and per-frame forwarding decision
`timescale 1ns/1ns
module sgfc_ctrl (
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  input  wire logic                     clk_en,
  input  wire logic                     phy_side_rx_error_strap,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic [7:0]                    reg_rdata,
  input  wire sgfc_pkg::sgfc_frame_s    frame_in,
  output sgfc_pkg::sgfc_decision_s      decision,
  output logic                          host_back_pressure,
  output sgfc_pkg::sgfc_ctrl_s          ctrl
);
  typedef enum logic [1:0] {
    SGFC_ST_STRAP  = 2'b00,
    SGFC_ST_SETTLE = 2'b11,
    SGFC_ST_LOAD   = 2'b01,
    SGFC_ST_RUN    = 2'b10
  } sgfc_state_e;

  sgfc_state_e              state;
  sgfc_state_e              next_state;
  logic                     strap_sync;
  sgfc_pkg::sgfc_ctrl_s     next_ctrl;
  logic [7:0]               next_rdata;
  sgfc_pkg::sgfc_decision_s next_decision;
  logic [7:0]               size_rd;
  logic [7:0]               fwd_rd;
  logic [7:0]               host_rd;
  logic [10:0]              limit;

  sgfc_sync u_strap_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .async_in (phy_side_rx_error_strap),
    .sync_out (strap_sync)
  );

  // (R16) Reserved bits zero
  always_comb begin
    size_rd = 8'h00;
    size_rd[sgfc_pkg::BIT_HUGE]      = ctrl.huge;
    size_rd[sgfc_pkg::BIT_LEGAL_DIS] = ctrl.legal_dis;
    fwd_rd = 8'h00;
    fwd_rd[sgfc_pkg::BIT_VLAN_EN]    = ctrl.vlan_en;
    fwd_rd[sgfc_pkg::BIT_IGMP_SNOOP] = ctrl.igmp_snoop;
    fwd_rd[sgfc_pkg::BIT_DIRECT]     = ctrl.direct;
    fwd_rd[sgfc_pkg::BIT_PRE_TAG]    = ctrl.pre_tag;
    fwd_rd[sgfc_pkg::BIT_TAG_MASK]   = ctrl.tag_mask;
    fwd_rd[sgfc_pkg::BIT_SNIFF_AND]  = ctrl.sniff_and;
    host_rd = 8'h00;
    host_rd[sgfc_pkg::BIT_BACK_PRESS] = ctrl.back_press;
  end

  always_comb begin
    next_state = state;
    next_ctrl  = ctrl;
    next_rdata = reg_rdata;
    case (state)
      // Pin needs two edges to settle through the synchroniser
      SGFC_ST_STRAP: begin
        next_state = SGFC_ST_SETTLE;
      end
      // Second stage shows the pin only after this edge
      SGFC_ST_SETTLE: begin
        next_state = SGFC_ST_LOAD;
      end
      SGFC_ST_LOAD: begin
        // (R15) Strap sets default
        next_ctrl.legal_dis = strap_sync;
        next_state = SGFC_ST_RUN;
      end
      SGFC_ST_RUN: begin
        if (reg_wr) begin
          if (reg_addr == sgfc_pkg::ADDR_FRAME_SIZE) begin
            // (R16) Reserved writes ignored
            next_ctrl.huge      = reg_wdata[sgfc_pkg::BIT_HUGE];
            next_ctrl.legal_dis = reg_wdata[sgfc_pkg::BIT_LEGAL_DIS];
          end else if (reg_addr == sgfc_pkg::ADDR_FORWARDING) begin
            // (R06) VLAN enable write
            next_ctrl.vlan_en    = reg_wdata[sgfc_pkg::BIT_VLAN_EN];
            next_ctrl.igmp_snoop = reg_wdata[sgfc_pkg::BIT_IGMP_SNOOP];
            next_ctrl.direct     = reg_wdata[sgfc_pkg::BIT_DIRECT];
            next_ctrl.pre_tag    = reg_wdata[sgfc_pkg::BIT_PRE_TAG];
            next_ctrl.tag_mask   = reg_wdata[sgfc_pkg::BIT_TAG_MASK];
            next_ctrl.sniff_and  = reg_wdata[sgfc_pkg::BIT_SNIFF_AND];
          end else if (reg_addr == sgfc_pkg::ADDR_HOST_PORT) begin
            next_ctrl.back_press = reg_wdata[sgfc_pkg::BIT_BACK_PRESS];
          end
        end
      end
      default: begin
        next_state = SGFC_ST_STRAP;
      end
    endcase
    if (reg_rd) begin
      if (reg_addr == sgfc_pkg::ADDR_FRAME_SIZE) begin
        next_rdata = size_rd;
      end else if (reg_addr == sgfc_pkg::ADDR_FORWARDING) begin
        next_rdata = fwd_rd;
      end else if (reg_addr == sgfc_pkg::ADDR_HOST_PORT) begin
        next_rdata = host_rd;
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_comb begin
    limit         = sgfc_pkg::LEN_UNTAGGED;
    next_decision = '0;
    // (R01) Huge frame wins
    if (ctrl.huge) begin
      limit = sgfc_pkg::LEN_HUGE;
    // (R02) Check disable limit
    end else if (ctrl.legal_dis) begin
      limit = sgfc_pkg::LEN_LEGAL_DIS;
    // (R03) (R04) Tagged limit, special tag excluded
    end else if (frame_in.vlan_tagged && !frame_in.special_tag) begin
      limit = sgfc_pkg::LEN_TAGGED;
    end
    next_decision.valid = frame_in.valid;
    // (R05) Oversize frame drop
    next_decision.drop  = frame_in.length > limit;
    next_decision.dest_ports = frame_in.lookup_ports;
    // (R11) (R10) Tag mask without VLAN
    if (ctrl.tag_mask && !ctrl.vlan_en) begin
      next_decision.dest_ports = frame_in.vid_low;
    end
    // (R07) IGMP to host port
    if (ctrl.igmp_snoop && frame_in.is_igmp) begin
      next_decision.dest_ports = 5'h10;
    end
    // (R08) Direct mode bypasses lookup
    if (ctrl.direct && frame_in.from_host) begin
      next_decision.dest_ports = frame_in.preamble_ports;
    end
    // (R12) (R13) Sniff AND or OR
    next_decision.mirror = ctrl.sniff_and ?
      (frame_in.sniff_src_hit && frame_in.sniff_dst_hit) :
      (frame_in.sniff_src_hit || frame_in.sniff_dst_hit);
    // (R09) Pre-tag toward host
    next_decision.pre_tag_en   = ctrl.pre_tag &&
                                 next_decision.dest_ports[4];
    next_decision.pre_tag_port = frame_in.src_port;
    if (!frame_in.valid) begin
      next_decision = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state              <= SGFC_ST_STRAP;
      ctrl               <= '0;
      reg_rdata          <= 8'h00;
      decision           <= '0;
      host_back_pressure <= 1'b0;
    end else if (clk_en) begin
      state              <= next_state;
      ctrl               <= next_ctrl;
      reg_rdata          <= next_rdata;
      decision           <= next_decision;
      // (R14) Host port backpressure
      host_back_pressure <= ctrl.back_press;
    end
  end
endmodule // sgfc_ctrl

// >>> sgfc_checker.sv
// Assertions on the frame control block ports
`timescale 1ns/1ns
module sgfc_checker (
  input wire logic                     clk_sys,
  input wire logic                     arst_n,
  input wire logic                     clk_en,
  input wire sgfc_pkg::sgfc_frame_s    frame_in,
  input wire sgfc_pkg::sgfc_decision_s decision,
  input wire sgfc_pkg::sgfc_ctrl_s     ctrl,
  input wire logic                     host_back_pressure
);
  logic        v;
  logic        dflt;
  logic        tg;
  logic        ig;
  logic        sa;
  logic        sd;
  logic [10:0] n;
  // Frozen edges take no frame
  assign v = frame_in.valid && clk_en;
  assign n = frame_in.length;
  assign dflt = v && !ctrl.huge && !ctrl.legal_dis;
  // Special-tagged CPU frames get the untagged limit
  assign tg = frame_in.vlan_tagged && !frame_in.special_tag;
  assign ig = v && ctrl.igmp_snoop && frame_in.is_igmp && !ctrl.direct;
  assign sa = frame_in.sniff_src_hit;
  assign sd = frame_in.sniff_dst_hit;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence s_drop;
    decision.valid && decision.drop;
  endsequence
  property p_huge; v && ctrl.huge && n > sgfc_pkg::LEN_HUGE |=> s_drop;
  endproperty
  a_huge: assert property (p_huge) else $error("huge limit");
  property p_legal; v && !ctrl.huge && ctrl.legal_dis &&
    n > sgfc_pkg::LEN_LEGAL_DIS
    |=> s_drop; endproperty
  a_legal: assert property (p_legal) else $error("1536 limit");
  property p_untag; dflt && !tg && n > sgfc_pkg::LEN_UNTAGGED |=> s_drop;
  endproperty
  a_untag: assert property (p_untag) else $error("1518 limit");
  property p_tag; dflt && tg && n <= sgfc_pkg::LEN_TAGGED |=>
    !decision.drop; endproperty
  a_tag: assert property (p_tag) else $error("1522 limit");
  property p_keep; v && n <= sgfc_pkg::LEN_UNTAGGED |=> !decision.drop;
  endproperty
  a_keep: assert property (p_keep) else $error("short drop");
  property p_igmp; ig && n <= sgfc_pkg::LEN_UNTAGGED |=>
    decision.dest_ports[4]; endproperty
  a_igmp: assert property (p_igmp) else $error("igmp snoop");
  property p_and; v && ctrl.sniff_and && sa != sd |=> !decision.mirror;
  endproperty
  a_and: assert property (p_and) else $error("sniff and");
  property p_or; v && !ctrl.sniff_and && sa |=> decision.mirror; endproperty
  a_or: assert property (p_or) else $error("sniff or");
  // Lag holds only when the previous edge was enabled
  property p_bp; $past(clk_en) |->
    host_back_pressure == $past(ctrl.back_press); endproperty
  a_bp: assert property (p_bp) else $error("back pressure");
endmodule // sgfc_checker

bind sgfc_ctrl sgfc_checker chk_u (.clk_sys(clk_sys), .arst_n(arst_n),
  .clk_en(clk_en),
  .frame_in(frame_in), .decision(decision), .ctrl(ctrl),
  .host_back_pressure(host_back_pressure));

// >>> sgfc_host.sv
// Host MAC model presenting frame descriptors
`timescale 1ns/1ns
module sgfc_host (
  input  wire logic             clk_sys,
  output sgfc_pkg::sgfc_frame_s frame
);
  initial frame = '0;
  task automatic send(input sgfc_pkg::sgfc_frame_s f);
    @(negedge clk_sys);
    frame = f;
    frame.valid = 1'b1;
    @(negedge clk_sys);
    // Idle fields inverted, never stale
    frame = ~f;
    frame.valid = 1'b0;
  endtask
endmodule // sgfc_host

// >>> testbench.sv
// Testbench for the global frame control block
`timescale 1ns/1ns
module testbench;
  logic                     clk_sys;
  logic                     arst_n;
  logic                     clk_en;
  logic                     strap;
  logic                     reg_wr;
  logic                     reg_rd;
  logic                     host_bp;
  logic [7:0]               reg_addr;
  logic [7:0]               reg_wdata;
  logic [7:0]               reg_rdata;
  sgfc_pkg::sgfc_frame_s    frame_in;
  sgfc_pkg::sgfc_frame_s    f;
  sgfc_pkg::sgfc_decision_s dec;
  sgfc_pkg::sgfc_ctrl_s     ctl;
  int                       errors = 0;
  int                       n_compared = 0;
  int                       lim;
  sgfc_ctrl dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .phy_side_rx_error_strap(strap), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .frame_in(frame_in), .decision(dec), .host_back_pressure(host_bp),
    .ctrl(ctl));
  sgfc_host host_u (.clk_sys(clk_sys), .frame(frame_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One strobe per access, released a full cycle later
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic go(input logic d);
    host_u.send(f);
    chk(8'({dec.valid, dec.drop}), 8'({1'b1, d}));
  endtask
  task automatic reset_dut(input logic s);
    strap = s;
    arst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic stop_test;
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    stop_test;
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    clk_en = 1'b1;
    f = '0;
    reset_dut(1'b0);
    for (int a = 4; a < 8; a++) begin
      bus(1'b0, 8'(a), 8'h00);
      chk(reg_rdata, 8'h00);
      bus(1'b1, 8'(a), 8'hff);
      bus(1'b0, 8'(a), 8'h00);
      chk(reg_rdata, a == 4 ? 8'h06 : a == 5 ? 8'hf3 : a == 6 ? 8'h80 : 8'h00);
    end
    @(negedge clk_sys);
    chk(8'(host_bp), 8'h01);
    bus(1'b1, 8'h06, 8'h00);
    @(negedge clk_sys);
    chk(8'(host_bp), 8'h00);
    // Frozen edge must not take a write
    clk_en = 1'b0;
    bus(1'b1, 8'h06, 8'h80);
    clk_en = 1'b1;
    bus(1'b0, 8'h06, 8'h00);
    chk(reg_rdata, 8'h00);
    chk(8'(host_bp), 8'h00);
    bus(1'b1, 8'h05, 8'h00);
    for (int s = 0; s < 8; s += 2) begin
      bus(1'b1, 8'h04, 8'(s));
      lim = s >= 4 ? 1916 : s == 2 ? 1536 : 1518;
      f.length = 11'(lim);
      go(1'b0);
      f.length = 11'(lim + 1);
      go(1'b1);
    end
    bus(1'b1, 8'h04, 8'h00);
    f.vlan_tagged = 1'b1;
    f.length = 11'h5f2;
    go(1'b0);
    f.special_tag = 1'b1;
    go(1'b1);
    f = '0;
    f.length = 11'h040;
    f.lookup_ports = 5'h01;
    f.vid_low = 5'h0a;
    bus(1'b1, 8'h05, 8'h02);
    go(1'b0);
    chk(8'(dec.dest_ports), 8'h0a);
    bus(1'b1, 8'h05, 8'h82);
    go(1'b0);
    chk(8'(dec.dest_ports), 8'h01);
    chk(8'(ctl.vlan_en), 8'h01);
    bus(1'b1, 8'h05, 8'h40);
    f.is_igmp = 1'b1;
    go(1'b0);
    chk(8'(dec.dest_ports[4]), 8'h01);
    bus(1'b1, 8'h05, 8'h20);
    f.from_host = 1'b1;
    f.preamble_ports = 5'h06;
    go(1'b0);
    chk(8'(dec.dest_ports), 8'h06);
    bus(1'b1, 8'h05, 8'h10);
    f = '0;
    f.lookup_ports = 5'h10;
    f.src_port = 3'h3;
    go(1'b0);
    chk(8'({dec.pre_tag_en, dec.pre_tag_port}), 8'h0b);
    bus(1'b1, 8'h05, 8'h01);
    f.sniff_src_hit = 1'b1;
    go(1'b0);
    chk(8'(dec.mirror), 8'h00);
    bus(1'b1, 8'h05, 8'h00);
    go(1'b0);
    chk(8'(dec.mirror), 8'h01);
    @(negedge clk_sys);
    chk(8'(|dec), 8'h00);
    reset_dut(1'b1);
    bus(1'b0, 8'h04, 8'h00);
    chk(reg_rdata, 8'h02);
    stop_test;
  end
endmodule // testbench
